//--- common/eeprom_host_pkg.sv
// Shared constants, types and timing counts for the parallel EEPROM page-write host.
// Assumes a 200 MHz system clock and an APB register port with 32-bit data.
package eeprom_host_pkg;
	// Memory array shape.
	localparam int ADDR_W     = 13;
	localparam int DATA_W     = 8;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_LSB   = 5;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] OFS_ADDR   = 8'h00;
	localparam logic [7:0] OFS_WDATA  = 8'h04;
	localparam logic [7:0] OFS_CMD    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_RDATA  = 8'h10;
	localparam logic [7:0] OFS_CFG    = 8'h14;

	// Command and status field positions.
	localparam int CMD_READ_BIT   = 0;
	localparam int CMD_WRITE_BIT  = 1;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_PAGE_BIT    = 1;
	localparam int ST_PROG_BIT    = 2;
	localparam int ST_READY_BIT   = 3;
	localparam int ST_ERR_BIT     = 4;
	localparam int ST_RDOK_BIT    = 5;
	localparam int ST_WROK_BIT    = 6;
	localparam int ST_COUNT_LSB   = 8;

	// Status bit positions on the data lines during programming.
	localparam int COMPLEMENT_POLL_BIT    = 7;
	localparam int ALTERNATING_STATUS_BIT = 6;

	// Timing in the units printed, and cycle counts derived from the clock period.
	localparam int CLK_PERIOD_PS          = 5000;
	localparam int READ_ACCESS_NS         = 150;
	localparam int WRITE_PULSE_NS         = 150;
	localparam int WRITE_HIGH_NS          = 200;
	localparam int RECOVER_NS             = 10;
	localparam int BYTE_LOAD_WINDOW_US    = 100;
	localparam int POWERUP_READ_DELAY_US  = 1;
	localparam int POWERUP_WRITE_DELAY_MS = 10;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_HIGH_CYC  = (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RECOVER_CYC     = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Longest time, so it rounds down.
	localparam int BYTE_WINDOW_CYC = int'(longint'(BYTE_LOAD_WINDOW_US) * 64'd1000000
		/ CLK_PERIOD_PS);
	localparam int PUR_CYC = int'((longint'(POWERUP_READ_DELAY_US) * 64'd1000000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int PUW_CYC = int'((longint'(POWERUP_WRITE_DELAY_MS) * 64'd1000000000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// How completion of programming is detected.
	typedef enum logic [1:0] {
		POLL_COMPLEMENT = 2'h0,
		POLL_ALTERNATE  = 2'h1,
		POLL_PIN        = 2'h2
	} poll_mode_t;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_RD_ACC = 3'h1,
		ST_RD_GAP = 3'h2,
		ST_WR_LOW = 3'h3,
		ST_WR_HI  = 3'h4,
		ST_PAGE   = 3'h5
	} state_t;

	// Pins driven toward the memory.
	typedef struct packed {
		logic [ADDR_W-1:0] addressLines;
		logic [DATA_W-1:0] dataLinesOut;
		logic              dataLinesOe;
		logic              chipSelN;
		logic              outGateN;
		logic              writeStrobeN;
	} eeprom_pins_t;

	// APB request from the bus master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// APB answer to the bus master.
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;
endpackage

//--- core/eeprom_page_host.sv
// Host-side controller for a byte-wide parallel EEPROM with page writes and status polling.
// Assumes the memory pins are sampled synchronously and the data wire is resolved outside.
//
// Notes on behaviour
// [RL1] Thirteen address lines pick one byte.
// [RL2] Chip select low for every access.
// [RL3] Read: select and gate low, strobe high.
// [RL4] Memory floats data when gate or select high.
// [RL5] Write needs strobe, select low, gate high.
// [RL6] Address latched on the later falling edge.
// [RL7] Data latched on the earlier rising edge.
// [RL8] Programming is self timed after writing.
// [RL9] Up to 32 bytes form one page.
// [RL10] Page address bits stay fixed per page.
// [RL11] Next byte within 100 us of last.
// [RL12] Memory programs after 100 us silence.
// [RL13] Status bits show only while programming.
// [RL14] Bit 7 inverted while programming last byte.
// [RL15] Bit 7 true once programming finishes.
// [RL16] Bit 6 alternates on each busy read.
// [RL17] First alternating read returns zero.
// [RL18] Alternation stops when programming ends.
// [RL19] Bit 5 reports the byte load timer.
// [RL20] Ready pin low during programming.
// [RL21] Power-up clears memory programming logic.
// [RL22] Wait 1 us after power-up to read.
// [RL23] Wait 10 ms after power-up to write.
// [RL24] Poll for completion before writing again.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module eeprom_page_host #(
	parameter int BYTE_WINDOW = eeprom_host_pkg::BYTE_WINDOW_CYC, // Byte load window, cycles.
	parameter int PUW_DELAY   = eeprom_host_pkg::PUW_CYC          // Power-up write wait, cycles.
) (
	input  wire logic                          clock,
	input  wire logic                          srst,
	input  wire eeprom_host_pkg::apb_req_t     apbReq,
	output var  eeprom_host_pkg::apb_rsp_t     apbRsp,
	output var  eeprom_host_pkg::eeprom_pins_t pins,
	input  wire logic [7:0]                    dataLinesIn,
	input  wire logic                          writeDoneOpenDrain
);
	import eeprom_host_pkg::*;

	state_t            st_q, st_d;             // Sequencer state.
	eeprom_pins_t      pins_q, pins_d;         // Registered pin drive.
	apb_rsp_t          rsp_q, rsp_d;           // Registered bus answer.
	logic [ADDR_W-1:0] addr_q, addr_d;         // Address for the next command.
	logic [ADDR_W-1:0] lastAddr_q, lastAddr_d; // Address of the last byte loaded.
	logic [DATA_W-1:0] wdata_q, wdata_d;       // Byte for the next write.
	logic [DATA_W-1:0] lastData_q, lastData_d; // Last byte loaded, for complement polling.
	logic [DATA_W-1:0] rdata_q, rdata_d;       // Byte returned by the last plain read.
	poll_mode_t        mode_q, mode_d;         // Completion detection method.
	logic [7:0]        pageBase_q, pageBase_d; // Page address of the open page.
	logic [5:0]        pageCnt_q, pageCnt_d;   // Bytes loaded in the open page.
	logic [7:0]        stepCnt_q, stepCnt_d;   // Cycle count inside one pin phase.
	logic [15:0]       winCnt_q, winCnt_d;     // Cycles since the last write strobe rose.
	logic [21:0]       puCnt_q, puCnt_d;       // Cycles since reset, saturating.
	logic              polling_q, polling_d;   // Waiting for programming to finish.
	logic              tglSeen_q, tglSeen_d;   // One alternating bit sample is held.
	logic              lastTgl_q, lastTgl_d;   // Previous alternating bit sample.
	logic              err_q, err_d;           // Sticky refused command flag.
	logic              readOk, writeOk, mapped, apbFire, wrFire, cmdRead, cmdWrite, done;
	logic              errSet;

	// Builds the pin drive that opens a read or a write access.
	function automatic eeprom_pins_t openAccess(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic wr);
		eeprom_pins_t p;
		p.addressLines = a;       // RL1
		p.dataLinesOut = d;
		p.dataLinesOe  = wr;      // Drive data only while writing, never against a read.
		p.chipSelN     = 1'b0;    // RL2
		p.outGateN     = wr;      // RL5
		p.writeStrobeN = ~wr;     // RL3
		return p;
	endfunction

	assign readOk   = puCnt_q >= 22'(PUR_CYC);   // RL22
	assign writeOk  = puCnt_q >= 22'(PUW_DELAY); // RL23
	assign mapped   = apbReq.paddr inside {OFS_ADDR, OFS_WDATA, OFS_CMD, OFS_STATUS, OFS_RDATA,
		OFS_CFG};
	assign apbFire  = apbReq.psel & apbReq.penable & rsp_q.pready;
	assign wrFire   = apbFire & apbReq.pwrite & mapped;
	assign cmdRead  = wrFire && apbReq.paddr == OFS_CMD && apbReq.pwdata[CMD_READ_BIT];
	assign cmdWrite = wrFire && apbReq.paddr == OFS_CMD && apbReq.pwdata[CMD_WRITE_BIT];

	// Completion test on the sample now on the data lines, or on the ready pin, by the chosen method.
	always_comb begin
		case (mode_q)
			POLL_COMPLEMENT: done = dataLinesIn[COMPLEMENT_POLL_BIT] ==
				lastData_q[COMPLEMENT_POLL_BIT]; // RL15
			POLL_ALTERNATE: done = tglSeen_q &&
				dataLinesIn[ALTERNATING_STATUS_BIT] == lastTgl_q; // RL18
			POLL_PIN: done = writeDoneOpenDrain; // RL20
			default: done = 1'b1;
		endcase
	end

	// Next values of the bus answer, the registers and the pin sequencer.
	always_comb begin
		st_d       = st_q;
		pins_d     = pins_q;
		addr_d     = addr_q;
		lastAddr_d = lastAddr_q;
		wdata_d    = wdata_q;
		lastData_d = lastData_q;
		rdata_d    = rdata_q;
		mode_d     = mode_q;
		pageBase_d = pageBase_q;
		pageCnt_d  = pageCnt_q;
		stepCnt_d  = stepCnt_q + 8'h01;
		winCnt_d   = (winCnt_q == 16'hffff) ? winCnt_q : winCnt_q + 16'h0001;
		puCnt_d    = (puCnt_q == 22'h3fffff) ? puCnt_q : puCnt_q + 22'h000001;
		polling_d  = polling_q;
		tglSeen_d  = tglSeen_q;
		lastTgl_d  = lastTgl_q;
		errSet     = 1'b0;
		rsp_d      = '0;
		// Access phase gets one wait state so the answer comes from flip-flops.
		if (apbReq.psel && apbReq.penable && !rsp_q.pready) begin
			rsp_d.pready  = 1'b1;
			rsp_d.pslverr = ~mapped;
			case (apbReq.paddr)
				OFS_ADDR:   rsp_d.prdata = {19'h0, addr_q};
				OFS_WDATA:  rsp_d.prdata = {24'h0, wdata_q};
				OFS_RDATA:  rsp_d.prdata = {24'h0, rdata_q};
				OFS_CFG:    rsp_d.prdata = {30'h0, mode_q};
				OFS_STATUS: begin
					rsp_d.prdata[ST_BUSY_BIT]  = st_q != ST_IDLE;
					rsp_d.prdata[ST_PAGE_BIT]  = st_q == ST_PAGE;
					rsp_d.prdata[ST_PROG_BIT]  = polling_q;
					rsp_d.prdata[ST_READY_BIT] = writeDoneOpenDrain;
					rsp_d.prdata[ST_ERR_BIT]   = err_q;
					rsp_d.prdata[ST_RDOK_BIT]  = readOk;
					rsp_d.prdata[ST_WROK_BIT]  = writeOk;
					rsp_d.prdata[ST_COUNT_LSB +: 6] = pageCnt_q;
				end
				default:    rsp_d.prdata = 32'h0;
			endcase
		end
		// Plain register writes.
		if (wrFire && apbReq.paddr == OFS_ADDR) begin
			addr_d = apbReq.pwdata[ADDR_W-1:0];
		end
		if (wrFire && apbReq.paddr == OFS_WDATA) begin
			wdata_d = apbReq.pwdata[DATA_W-1:0];
		end
		if (wrFire && apbReq.paddr == OFS_CFG) begin
			mode_d = poll_mode_t'(apbReq.pwdata[1:0]);
		end
		// Sequencer.
		case (st_q)
			ST_IDLE: begin
				if (cmdRead && readOk) begin
					pins_d    = openAccess(addr_q, wdata_q, 1'b0);
					stepCnt_d = 8'h00;
					st_d      = ST_RD_ACC;
				end else if (cmdWrite && writeOk) begin
					pins_d     = openAccess(addr_q, wdata_q, 1'b1); // RL5
					lastAddr_d = addr_q;
					lastData_d = wdata_q;
					pageBase_d = addr_q[ADDR_W-1:PAGE_LSB];
					pageCnt_d  = 6'd1; // RL9
					stepCnt_d  = 8'h00;
					st_d       = ST_WR_LOW;
				end else if (cmdRead || cmdWrite) begin
					errSet = 1'b1;
				end
			end
			ST_RD_ACC: begin
				// Hold select and gate low for the full access time, then sample.
				if (stepCnt_q == 8'(READ_ACCESS_CYC - 1)) begin
					if (polling_q) begin
						polling_d = ~done; // RL24
						tglSeen_d = 1'b1;
						lastTgl_d = dataLinesIn[ALTERNATING_STATUS_BIT];
					end else begin
						rdata_d = dataLinesIn; // RL3
					end
					pins_d.chipSelN = 1'b1;
					pins_d.outGateN = 1'b1;
					stepCnt_d       = 8'h00;
					st_d            = ST_RD_GAP;
				end
				errSet = cmdRead || cmdWrite;
			end
			ST_RD_GAP: begin
				// Recovery gap, then either poll again or go idle.
				if (stepCnt_q == 8'(RECOVER_CYC - 1)) begin
					if (polling_q) begin
						pins_d    = openAccess(lastAddr_q, lastData_q, 1'b0); // RL24
						stepCnt_d = 8'h00;
						st_d      = ST_RD_ACC;
					end else begin
						st_d = ST_IDLE;
					end
				end
				errSet = cmdRead || cmdWrite;
			end
			ST_WR_LOW: begin
				// Select and strobe rise together; the memory latches data here.
				if (stepCnt_q == 8'(WRITE_PULSE_CYC - 1)) begin
					pins_d.writeStrobeN = 1'b1;
					pins_d.chipSelN     = 1'b1;
					winCnt_d            = 16'h0000;
					stepCnt_d           = 8'h00;
					st_d                = ST_WR_HI;
				end
				errSet = cmdRead || cmdWrite;
			end
			ST_WR_HI: begin
				// Strobe high time before another byte may be loaded.
				if (stepCnt_q == 8'(WRITE_HIGH_CYC - 1)) begin
					pins_d.dataLinesOe = 1'b0;
					st_d               = ST_PAGE;
				end
				errSet = cmdRead || cmdWrite;
			end
			ST_PAGE: begin
				if (cmdWrite && pageCnt_q < 6'(PAGE_BYTES) &&
					addr_q[ADDR_W-1:PAGE_LSB] == pageBase_q &&
					winCnt_q < 16'(BYTE_WINDOW - 1)) begin // RL11
					pins_d     = openAccess(addr_q, wdata_q, 1'b1); // RL10
					lastAddr_d = addr_q;
					lastData_d = wdata_q;
					pageCnt_d  = pageCnt_q + 6'd1; // RL9
					stepCnt_d  = 8'h00;
					st_d       = ST_WR_LOW;
				end else begin
					errSet = cmdRead || cmdWrite;
					// Window over: the memory is programming, so start polling.
					if (winCnt_q >= 16'(BYTE_WINDOW)) begin
						pins_d    = openAccess(lastAddr_q, lastData_q, 1'b0); // RL24
						polling_d = 1'b1;
						tglSeen_d = 1'b0;
						stepCnt_d = 8'h00;
						st_d      = ST_RD_ACC;
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
		// Refusal flag: write one to clear, a new refusal in the same cycle wins.
		err_d = err_q;
		if (wrFire && apbReq.paddr == OFS_STATUS && apbReq.pwdata[ST_ERR_BIT]) begin
			err_d = 1'b0;
		end
		if (errSet) begin
			err_d = 1'b1;
		end
	end

	// Registers every state element; synchronous reset to idle, pins inactive.
	always_ff @(posedge clock) begin
		if (srst) begin
			st_q       <= ST_IDLE;
			pins_q     <= '{addressLines: '0, dataLinesOut: '0, dataLinesOe: 1'b0,
				chipSelN: 1'b1, outGateN: 1'b1, writeStrobeN: 1'b1};
			rsp_q      <= '0;
			addr_q     <= '0;
			lastAddr_q <= '0;
			wdata_q    <= '0;
			lastData_q <= '0;
			rdata_q    <= '0;
			mode_q     <= POLL_COMPLEMENT;
			pageBase_q <= '0;
			pageCnt_q  <= '0;
			stepCnt_q  <= '0;
			winCnt_q   <= '0;
			puCnt_q    <= '0;
			polling_q  <= 1'b0;
			tglSeen_q  <= 1'b0;
			lastTgl_q  <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			st_q       <= st_d;
			pins_q     <= pins_d;
			rsp_q      <= rsp_d;
			addr_q     <= addr_d;
			lastAddr_q <= lastAddr_d;
			wdata_q    <= wdata_d;
			lastData_q <= lastData_d;
			rdata_q    <= rdata_d;
			mode_q     <= mode_d;
			pageBase_q <= pageBase_d;
			pageCnt_q  <= pageCnt_d;
			stepCnt_q  <= stepCnt_d;
			winCnt_q   <= winCnt_d;
			puCnt_q    <= puCnt_d;
			polling_q  <= polling_d;
			tglSeen_q  <= tglSeen_d;
			lastTgl_q  <= lastTgl_d;
			err_q      <= err_d;
		end
	end

	assign pins   = pins_q;
	assign apbRsp = rsp_q;

	// A byte load after the first one of a page.
	sequence s_laterByte;
		$fell(pins_q.writeStrobeN) && pageCnt_q > 6'd1;
	endsequence
	// A read access opening.
	sequence s_readOpen;
		$fell(pins_q.outGateN);
	endsequence

	property p_writeGate;
		@(posedge clock) disable iff (srst)
		!pins_q.writeStrobeN |-> !pins_q.chipSelN && pins_q.outGateN && pins_q.dataLinesOe;
	endproperty
	a_writeGate: assert property (p_writeGate) else $error("write strobe without gate high"); // RL5
	property p_selWithGate;
		@(posedge clock) disable iff (srst)
		!pins_q.outGateN |-> !pins_q.chipSelN && pins_q.writeStrobeN;
	endproperty
	a_selWithGate: assert property (p_selWithGate) else $error("gate low without select"); // RL2
	property p_readNoDrive;
		@(posedge clock) disable iff (srst)
		s_readOpen |-> !pins_q.dataLinesOe ##1 !pins_q.outGateN ##1 !pins_q.outGateN;
	endproperty
	a_readNoDrive: assert property (p_readNoDrive) else $error("read access too short"); // RL3
	property p_samePage;
		@(posedge clock) disable iff (srst)
		s_laterByte |-> pins_q.addressLines[ADDR_W-1:PAGE_LSB] == pageBase_q;
	endproperty
	a_samePage: assert property (p_samePage) else $error("byte outside open page"); // RL10
	property p_inWindow;
		@(posedge clock) disable iff (srst)
		s_laterByte |-> $past(winCnt_q) < 16'(BYTE_WINDOW);
	endproperty
	a_inWindow: assert property (p_inWindow) else $error("byte after load window"); // RL11
	property p_pageSize;
		@(posedge clock) disable iff (srst)
		$fell(pins_q.writeStrobeN) |-> pageCnt_q >= 6'd1 && pageCnt_q <= 6'(PAGE_BYTES);
	endproperty
	a_pageSize: assert property (p_pageSize) else $error("page byte count out of range"); // RL9
	property p_readDelay;
		@(posedge clock) disable iff (srst)
		!pins_q.outGateN |-> puCnt_q > 22'(PUR_CYC);
	endproperty
	a_readDelay: assert property (p_readDelay) else $error("read before power-up delay"); // RL22
	property p_writeDelay;
		@(posedge clock) disable iff (srst)
		!pins_q.writeStrobeN |-> puCnt_q > 22'(PUW_DELAY);
	endproperty
	a_writeDelay: assert property (p_writeDelay) else $error("write before power-up delay"); // RL23
	property p_noWriteWhilePolling;
		@(posedge clock) disable iff (srst)
		polling_q |-> pins_q.writeStrobeN ##1 (pins_q.writeStrobeN || !$past(polling_q));
	endproperty
	a_noWriteWhilePolling: assert property (p_noWriteWhilePolling)
		else $error("write during programming"); // RL24
endmodule
`default_nettype wire

//--- bench/eeprom_device_model.sv
// Behavioural page-write EEPROM that answers the host pins, sampled on the system clock.
// Assumes the bench resolves the shared data wire; the ready pin level is driven here, high when not programming.
`timescale 1ns/1ps
`default_nettype none
module eeprom_device_model #(
	parameter int LOAD_WINDOW = 200 // Byte load window in cycles.
) (
	input  wire logic                          clock,
	input  wire logic                          srst,
	input  wire eeprom_host_pkg::eeprom_pins_t pins,
	input  wire logic [15:0]                   progLen,
	output logic [7:0]                         busLevel,
	output logic                               readyLevel
);
	import eeprom_host_pkg::*;
	logic [7:0]  mem [8192];    // Storage, erased to all ones.
	logic [7:0]  pageData [32]; // Bytes latched for the open page.
	logic [31:0] pageHit;       // Page slots that were loaded.
	logic [12:0] wrAddr;        // Last latched write address.
	logic [7:0]  lastData;      // Last latched write byte.
	logic [7:0]  lastLevel;     // Level left on the wire last cycle.
	logic        wrPrev;        // Write condition one cycle ago.
	logic        rdPrev;        // Read condition one cycle ago.
	logic        loading;       // Page load timer is running.
	logic        toggle;        // Alternating status value.
	int          loadCnt;       // Cycles since the last byte.
	int          progCnt;       // Programming cycles still to run.
	wire logic   wrAct = !pins.chipSelN && !pins.writeStrobeN && pins.outGateN;
	wire logic   rdAct = !pins.chipSelN && !pins.outGateN && pins.writeStrobeN;
	// The pin is pulled up and only sunk while programming runs.
	assign readyLevel = (progCnt == 0);
	initial for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
	// Latching, page timer and the self-timed programming sequence.
	always @(posedge clock) begin
		wrPrev <= wrAct;
		rdPrev <= rdAct;
		lastLevel <= busLevel;
		if (srst) begin
			// A known level to start from, so the idle wire never stays unknown.
			lastLevel <= 8'h00;
			loading <= 1'b0;
			progCnt <= 0;
			pageHit <= '0;
		end else if (progCnt != 0) begin
			// Busy: writes are ignored and every finished read flips the toggle.
			progCnt <= progCnt - 1;
			if (!rdAct && rdPrev) toggle <= ~toggle;
			if (progCnt == 1) begin
				for (int i = 0; i < 32; i++)
					if (pageHit[i]) mem[{wrAddr[12:5], i[4:0]}] <= pageData[i];
				pageHit <= '0;
			end
		end else begin
			if (wrAct && !wrPrev) wrAddr <= pins.addressLines;
			if (!wrAct && wrPrev) begin
				pageData[wrAddr[4:0]] <= pins.dataLinesOut;
				pageHit[wrAddr[4:0]] <= 1'b1;
				lastData <= pins.dataLinesOut;
				loading <= 1'b1;
				loadCnt <= 0;
			end else if (loading) begin
				loadCnt <= loadCnt + 1;
				if (loadCnt == LOAD_WINDOW - 1) begin
					loading <= 1'b0;
					progCnt <= int'(progLen);
					toggle <= 1'b0;
				end
			end
		end
	end
	// The wire is driven only in a read; otherwise it shows a level that keeps changing.
	always_comb begin
		if (!rdAct) busLevel = ~lastLevel;
		else if (progCnt == 0) busLevel = mem[pins.addressLines];
		else busLevel = {(pins.addressLines == wrAddr) ? ~lastData[7] : lastData[7],
			toggle, 1'b1, ~lastLevel[4:0]};
	end
endmodule
`default_nettype wire

//--- bench/eeprom_page_host_tb.sv
// Self-checking bench for the page-write host, with a behavioural memory on its pins.
// Assumes shortened counts: 200 cycles of byte load window and 300 of power-up write delay.
`timescale 1ns/1ps
`default_nettype none
module eeprom_page_host_tb;
	import eeprom_host_pkg::*;
	localparam int WIN = 200; // Shortened byte load window.
	localparam int PUW = 300; // Shortened power-up write delay.
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] expRd;
		logic        expErr;
	} row_t;
	logic         clock;
	logic         srst;
	apb_req_t     apbReq;
	apb_rsp_t     apbRsp;
	eeprom_pins_t pins;
	logic [7:0]   busLevel;
	logic [7:0]   dataLinesIn;
	logic         readyLevel;
	logic [15:0]  progLen;     // Programming length the memory uses.
	logic [31:0]  rd;          // Read data of the last transfer.
	logic         err;         // Error answer of the last transfer.
	int           failCount = 0;
	int           checkCount = 0;
	int           cycles = 0;
	// Register rows: address width, field widths, write-only and unmapped places.
	row_t rows [8] = '{
		'{1'b1, OFS_ADDR, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, OFS_ADDR, 32'h0, 32'h1fff, 1'b0},
		'{1'b1, OFS_WDATA, 32'h123456a5, 32'h0, 1'b0}, '{1'b0, OFS_WDATA, 32'h0, 32'ha5, 1'b0},
		'{1'b1, OFS_CFG, 32'hfffffff6, 32'h0, 1'b0}, '{1'b0, OFS_CFG, 32'h0, 32'h2, 1'b0},
		'{1'b0, OFS_CMD, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h18, 32'h1, 32'h0, 1'b1}};
	// The host drives the wire while enabled; otherwise the memory's level is seen.
	assign dataLinesIn = pins.dataLinesOe ? pins.dataLinesOut : busLevel;
	eeprom_page_host #(.BYTE_WINDOW(WIN), .PUW_DELAY(PUW)) dut_u (
		.clock(clock), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .pins(pins),
		.dataLinesIn(dataLinesIn), .writeDoneOpenDrain(readyLevel));
	eeprom_device_model #(.LOAD_WINDOW(WIN)) mem_u (.clock(clock), .srst(srst), .pins(pins),
		.progLen(progLen), .busLevel(busLevel), .readyLevel(readyLevel));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Prints the verdict and ends the run.
	task automatic giveVerdict();
		if (failCount == 0 && checkCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// A hang is cut short and counted as a mismatch.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failCount++;
			giveVerdict();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; entered just after a rising edge, held until pready is sampled.
	// Only the bench timeout ends a wait that never sees pready.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge clock);
	endtask
	task automatic writeByte(input logic [12:0] a, input logic [7:0] d);
		apb(1'b1, OFS_ADDR, {19'h0, a});
		apb(1'b1, OFS_WDATA, {24'h0, d});
		apb(1'b1, OFS_CMD, 32'h2);
	endtask
	// Polls the status word until the sequencer is idle; a hang ends at the bench timeout.
	task automatic waitIdle();
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
		end while (rd[ST_BUSY_BIT] !== 1'b0);
	endtask
	task automatic readByte(input logic [12:0] a);
		apb(1'b1, OFS_ADDR, {19'h0, a});
		apb(1'b1, OFS_CMD, 32'h1);
		waitIdle();
		apb(1'b0, OFS_RDATA, 32'h0);
	endtask
	initial begin
		apbReq = '0;
		srst = 1'b1;
		progLen = 16'd100;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].wdata);
			if (!rows[i].wr) check(rd, rows[i].expRd);
			check({31'h0, err}, {31'h0, rows[i].expErr});
		end
		// Too early for a read: refused with no pin activity.
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
		check({31'h0, pins.chipSelN}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h10);
		repeat (160) @(posedge clock);
		// Reads now allowed, writes still too early.
		writeByte(13'h040, 8'h11);
		apb(1'b0, OFS_STATUS, 32'h0);
		check({29'h0, rd[ST_WROK_BIT], rd[ST_RDOK_BIT], rd[ST_ERR_BIT]}, 32'h3);
		apb(1'b1, OFS_STATUS, 32'h10);
		repeat (100) @(posedge clock);
		// Every polling mode, with a prompt and then slower programming time.
		for (int m = 0; m < 3; m++) begin
			progLen <= 16'(50 + 350 * m);
			apb(1'b1, OFS_CFG, 32'(m));
			writeByte(13'h0a0 + 13'(m), 8'hc3 ^ 8'(m));
			waitIdle();
			check({30'h0, rd[ST_READY_BIT], rd[ST_ERR_BIT]}, 32'h2);
			readByte(13'h0a0 + 13'(m));
			check(rd, {24'h0, 8'hc3 ^ 8'(m)});
		end
		// A full page of 32 bytes; the 33rd is refused.
		for (int k = 0; k < 33; k++) begin
			writeByte(13'h1e0 + 13'(k % 32), 8'(k) ^ 8'h3c);
			repeat (72) @(posedge clock);
		end
		apb(1'b0, OFS_STATUS, 32'h0);
		check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
		check(rd & 32'h00003fff, 32'h0000207b);
		apb(1'b1, OFS_STATUS, 32'h10);
		waitIdle();
		// A command during a write and a byte from another page are both refused.
		writeByte(13'h300, 8'h77);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h10);
		repeat (72) @(posedge clock);
		writeByte(13'h320, 8'h88);
		apb(1'b0, OFS_STATUS, 32'h0);
		check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
		waitIdle();
		readByte(13'h320);
		check(rd, 32'hff);
		readByte(13'h300);
		check(rd, 32'h77);
		readByte(13'h1e0);
		check(rd, 32'h3c);
		readByte(13'h1ff);
		check(rd, 32'h23);
		// A second reset idles the pins and restarts the power-up delays.
		srst <= 1'b1;
		repeat (20) @(posedge clock);
		check({7'h0, pins}, {7'h0, 13'h0, 8'h0, 4'h7});
		srst <= 1'b0;
		@(posedge clock);
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check({31'h0, rd[ST_ERR_BIT]}, 32'h1);
		giveVerdict();
	end
endmodule
`default_nettype wire
